// ### epc_clk_mon.sv
// Clock presence monitor: synchronises a pin clock and flags missing edges
`timescale 1ns/1ps
module epc_clk_mon (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_pin,
  output logic      present,
  output logic      rise
);
  logic [1:0] sync_q;
  logic       last_q;
  logic [6:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_q <= 2'h0;
      last_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[0], clk_pin};
      last_q <= sync_q[1];
    end
  end

  assign rise = sync_q[1] & ~last_q;

  // Counts since the last edge; saturating keeps a dead clock flagged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= epc_pkg::PRES_WIN7;
    else if (rise)
      cnt_q <= 7'h00;
    else if (cnt_q != epc_pkg::PRES_WIN7)
      cnt_q <= cnt_q + 7'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      present <= 1'b0;
    else
      present <= (cnt_q != epc_pkg::PRES_WIN7);
  end
endmodule

// ### epc_crc_path.sv
// One E1 direction: transparent pass, CRC4 regeneration hooks, AIS and Sa6 insertion
`timescale 1ns/1ps
module epc_crc_path (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       bit_stb,
  input  wire logic       in_bit,
  input  wire logic       regen,
  input  wire logic [1:0] frame_in_smf,
  input  wire logic       sa6_slot,
  input  wire logic [3:0] sa6_code,
  input  wire logic       sa6_ins,
  input  wire logic       ais,
  output logic            out_bit
);
  logic sa6_bit;

  // MSB of the code goes in the first frame of the sub-multiframe
  always_comb
  begin
    sa6_bit = 1'b0;
    case (frame_in_smf)
      2'd0:    sa6_bit = sa6_code[3];
      2'd1:    sa6_bit = sa6_code[2];
      2'd2:    sa6_bit = sa6_code[1];
      default: sa6_bit = sa6_code[0];
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_bit <= 1'b1;
    else if (bit_stb)
    begin
      if (ais)
        out_bit <= 1'b1;
      else if (regen && sa6_ins && sa6_slot)
        out_bit <= sa6_bit;
      else
        out_bit <= in_bit;
    end
  end
endmodule

// ### epc_e1_model.sv
// Behavioural E1 line equipment: bit strobes, frame position and random data
`timescale 1ns/1ps
module epc_e1_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic       bit_stb,
  output logic [1:0] frame_in_smf,
  output logic       sa6_slot,
  output logic       to_net_in,
  output logic       to_user_in
);
  logic [1:0] div_q;
  logic [3:0] bit_q;
  // Data toggle between strobes so that a sample one or three cycles after the strobe never looks right
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {div_q, bit_q} <= 6'h00;
      {bit_stb, frame_in_smf, sa6_slot, to_net_in, to_user_in} <= 6'h00;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      bit_stb <= div_q == 2'h3;
      sa6_slot <= div_q == 2'h3 && bit_q == 4'h5;
      if (div_q == 2'h3)
      begin
        to_net_in <= 1'($urandom);
        to_user_in <= 1'($urandom);
        bit_q <= bit_q + 4'h1;
        frame_in_smf <= frame_in_smf + 2'(bit_q == 4'hF);
      end
      else
      begin
        to_net_in <= ~to_net_in;
        to_user_in <= ~to_user_in;
      end
    end
  end
endmodule

// ### epc_pkg.sv
// Shared constants for the E1 PRA CRC4 and clock select block
package epc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CNT_U  = 8'h08;
  localparam logic [7:0] ADDR_CNT_N  = 8'h0C;
  // Control field positions
  localparam int CTRL_EXT_EN  = 0;
  localparam int CTRL_CUST    = 1;
  localparam int CTRL_ROLE_LO = 2;
  localparam int CTRL_OPT_LO  = 4;
  localparam int CTRL_SA6_EN  = 6;
  localparam int CTRL_AIS_EN  = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0094;
  // Roles
  typedef enum logic [1:0] {
    ROLE_NT1  = 2'b00,
    ROLE_LT   = 2'b01,
    ROLE_BOTH = 2'b10
  } epc_role_t;
  // Subscriber access options
  typedef enum logic [1:0] {
    OPT1 = 2'b00,
    OPT2 = 2'b01,
    OPT3 = 2'b10,
    OPT4 = 2'b11
  } epc_opt_t;
  // Clock sources
  typedef enum logic [1:0] {
    SRC_INT = 2'b00,
    SRC_TX  = 2'b01,
    SRC_EXT = 2'b10,
    SRC_REM = 2'b11
  } epc_src_t;
  // Sa6 codes
  localparam logic [3:0] SA6_NONE = 4'h0;
  localparam logic [3:0] SA6_EBIT = 4'h1;
  localparam logic [3:0] SA6_CRC  = 4'h2;
  localparam logic [3:0] SA6_BOTH = 4'h3;
  // Timing
  localparam int  CLK_HZ        = 200_000_000;
  localparam int  RESEL_MS      = 100;
  localparam int  RESEL_CYCLES  = CLK_HZ / 1000 * RESEL_MS;
  // Clock presence: an edge expected within this many aclk cycles
  localparam int  PRES_WINDOW   = 64;
  localparam logic [6:0] PRES_WIN7 = 7'h40;
endpackage

// ### epc_top.sv
// E1 PRA CRC4 option handling and E1 reference clock selection with AXI4-Lite registers
`timescale 1ns/1ps
// Overview of operation
// - External reference on, not a customer unit: use external 2048kHz, else transmit clock, else internal.
// - External reference off: use transmit clock, internal oscillator when E1 is silent.
// - External reference never times the receive direction.
// - Customer unit receive: recovered remote clock first, else internal clock.
// - Role is configurable: network termination, line termination, or both.
// - Option 1 passes frames transparently, no CRC4 generation or check.
// - Option 1 sends AIS opposite a side that lost its signal.
// - Option 1 still reports signal and alignment loss, but counts no CRC4 errors.
// - Option 2 regenerates CRC4 both ways and checks both sides.
// - User CRC error: E-bit back to user, Sa6 to exchange if enabled.
// - Exchange CRC error: E-bit back toward exchange.
// - Option 3: line unit regenerates and checks; combined role rejects it.
// - Option 4 forwards unchanged but counts CRC4 errors from both sides.
// - Option 4 sends AIS opposite a side with signal or alignment loss.
// - Sa6 codes: 0001 user E-bit, 0010 local CRC error, 0011 both.
// - Sa6 notification off: incoming Sa6 bits pass unchanged.
// - Sa6 notification active only with option 2.
// - AIS is unframed all ones.
// - Clock selection re-evaluated every 100 ms.
module epc_top #(
  parameter int RESEL_CYCLES = epc_pkg::RESEL_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_ref_clk,
  input  wire logic        e1_tx_clk,
  input  wire logic        rem_rx_clk,
  // Framer status from the E1 line logic (same clock)
  input  wire logic        u_los,
  input  wire logic        u_lof,
  input  wire logic        u_crc_err,
  input  wire logic        u_ebit_rx,
  input  wire logic        n_los,
  input  wire logic        n_lof,
  input  wire logic        n_crc_err,
  input  wire logic        bit_stb,
  input  wire logic [1:0]  frame_in_smf,
  input  wire logic        sa6_slot,
  input  wire logic        to_net_in,
  input  wire logic        to_user_in,
  output logic             to_net_out,
  output logic             to_user_out,
  output logic [1:0]       tx_ref_sel,
  output logic [1:0]       rx_ref_sel,
  output logic             crc_regen_net,
  output logic             crc_regen_user,
  output logic             crc_check,
  output logic             ebit_to_user,
  output logic             ebit_to_net
);
  logic [31:0] ctrl_q;
  logic [15:0] cnt_u_q;
  logic [15:0] cnt_n_q;
  logic [1:0]  tx_sel_q;
  logic [1:0]  rx_sel_q;
  logic [31:0] tick_q;
  logic        ext_pres;
  logic        tx_pres;
  logic        rem_pres;
  logic        opt_bad;
  logic        regen;
  logic        sa6_ins;
  logic        ais_to_net;
  logic        ais_to_user;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  epc_pkg::epc_role_t role;
  epc_pkg::epc_opt_t  opt;
  assign role = epc_pkg::epc_role_t'(ctrl_q[epc_pkg::CTRL_ROLE_LO +: 2]);
  assign opt  = epc_pkg::epc_opt_t'(ctrl_q[epc_pkg::CTRL_OPT_LO +: 2]);
  // Byte-lane merge used by the control register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction
  epc_clk_mon u_ext (.aclk(aclk), .aresetn(aresetn), .clk_pin(ext_ref_clk),
                     .present(ext_pres), .rise());
  epc_clk_mon u_tx  (.aclk(aclk), .aresetn(aresetn), .clk_pin(e1_tx_clk),
                     .present(tx_pres), .rise());
  epc_clk_mon u_rem (.aclk(aclk), .aresetn(aresetn), .clk_pin(rem_rx_clk),
                     .present(rem_pres), .rise());
  // AXI write channel: address and data taken in either order
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign do_write = (aw_hold_q | (s_axi_awvalid & s_axi_awready)) &
                    (w_hold_q | (s_axi_wvalid & s_axi_wready));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else if (do_write)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_hold_q ? wdata_q : s_axi_wdata;
  assign ws = w_hold_q ? wstrb_q : s_axi_wstrb;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ({wa[7:2], 2'b00} == epc_pkg::ADDR_CTRL) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= epc_pkg::CTRL_RESET;
    else if (do_write && {wa[7:2], 2'b00} == epc_pkg::ADDR_CTRL)
      ctrl_q <= merge(ctrl_q, wd, ws) & 32'h0000_00FF;
  end
  // Read channel: one cycle to data
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        epc_pkg::ADDR_CTRL:   s_axi_rdata <= ctrl_q;
        epc_pkg::ADDR_STATUS: s_axi_rdata <= {20'h0, opt_bad, rem_pres, tx_pres, ext_pres,
                                              n_lof, n_los, u_lof, u_los,
                                              rx_sel_q, tx_sel_q};
        epc_pkg::ADDR_CNT_U:  s_axi_rdata <= {16'h0, cnt_u_q};
        epc_pkg::ADDR_CNT_N:  s_axi_rdata <= {16'h0, cnt_n_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // Periodic reselection: sources change only on the tick, avoiding chatter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_q <= 32'h0000_0000;
    else if (tick_q >= 32'(RESEL_CYCLES - 1))
      tick_q <= 32'h0000_0000;
    else
      tick_q <= tick_q + 32'h0000_0001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_sel_q <= epc_pkg::SRC_INT;
      rx_sel_q <= epc_pkg::SRC_INT;
    end
    else if (tick_q >= 32'(RESEL_CYCLES - 1))
    begin
      if (ctrl_q[epc_pkg::CTRL_EXT_EN] && !ctrl_q[epc_pkg::CTRL_CUST] && ext_pres)
        tx_sel_q <= epc_pkg::SRC_EXT;
      else if (tx_pres && !u_los)
        tx_sel_q <= epc_pkg::SRC_TX;
      else
        tx_sel_q <= epc_pkg::SRC_INT;
      // Receive side never picks the external reference
      if (ctrl_q[epc_pkg::CTRL_CUST] && rem_pres)
        rx_sel_q <= epc_pkg::SRC_REM;
      else
        rx_sel_q <= epc_pkg::SRC_INT;
    end
  end
  assign tx_ref_sel = tx_sel_q;
  assign rx_ref_sel = rx_sel_q;
  // Option decode
  assign opt_bad = (opt == epc_pkg::OPT3) && (role == epc_pkg::ROLE_BOTH);
  always_comb
  begin
    regen          = 1'b0;
    crc_regen_net  = 1'b0;
    crc_regen_user = 1'b0;
    crc_check      = 1'b0;
    case (opt)
      epc_pkg::OPT1: crc_check = 1'b0;
      epc_pkg::OPT2:
      begin
        regen          = 1'b1;
        crc_regen_net  = 1'b1;
        crc_regen_user = 1'b1;
        crc_check      = 1'b1;
      end
      epc_pkg::OPT3:
      begin
        // Rejected combination falls back to transparent pass
        regen          = ~opt_bad;
        crc_regen_net  = ~opt_bad;
        crc_regen_user = ~opt_bad;
        crc_check      = ~opt_bad;
      end
      default: crc_check = 1'b1;
    endcase
  end
  assign ais_to_net = ctrl_q[epc_pkg::CTRL_AIS_EN] &&
                      ((opt == epc_pkg::OPT1 && u_los) ||
                       (opt == epc_pkg::OPT4 && (u_los || u_lof)));
  assign ais_to_user = ctrl_q[epc_pkg::CTRL_AIS_EN] &&
                       ((opt == epc_pkg::OPT1 && n_los) ||
                        (opt == epc_pkg::OPT4 && (n_los || n_lof)));
  assign sa6_ins = ctrl_q[epc_pkg::CTRL_SA6_EN] && opt == epc_pkg::OPT2;
  // Sa6 error flags gathered over a sub-multiframe, latched at its end
  logic e_acc_q;
  logic c_acc_q;
  logic [3:0] sa6_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      e_acc_q <= 1'b0;
      c_acc_q <= 1'b0;
      sa6_q   <= epc_pkg::SA6_NONE;
    end
    else if (bit_stb && sa6_slot && frame_in_smf == 2'd3)
    begin
      e_acc_q <= 1'b0;
      c_acc_q <= 1'b0;
      if (!sa6_ins)
        sa6_q <= epc_pkg::SA6_NONE;
      else if ((e_acc_q | u_ebit_rx) && (c_acc_q | u_crc_err))
        sa6_q <= epc_pkg::SA6_BOTH;
      else if (e_acc_q | u_ebit_rx)
        sa6_q <= epc_pkg::SA6_EBIT;
      else if (c_acc_q | u_crc_err)
        sa6_q <= epc_pkg::SA6_CRC;
      else
        sa6_q <= epc_pkg::SA6_NONE;
    end
    else
    begin
      e_acc_q <= e_acc_q | u_ebit_rx;
      c_acc_q <= c_acc_q | u_crc_err;
    end
  end
  // E-bit back-reporting and error counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ebit_to_user <= 1'b0;
      ebit_to_net  <= 1'b0;
      cnt_u_q      <= 16'h0000;
      cnt_n_q      <= 16'h0000;
    end
    else
    begin
      ebit_to_user <= regen & u_crc_err;
      ebit_to_net  <= regen & n_crc_err;
      if (crc_check && u_crc_err && cnt_u_q != 16'hFFFF)
        cnt_u_q <= cnt_u_q + 16'h0001;
      if (crc_check && n_crc_err && cnt_n_q != 16'hFFFF)
        cnt_n_q <= cnt_n_q + 16'h0001;
    end
  end
  epc_crc_path u_to_net (
    .aclk(aclk), .aresetn(aresetn), .bit_stb(bit_stb), .in_bit(to_net_in),
    .regen(regen), .frame_in_smf(frame_in_smf), .sa6_slot(sa6_slot),
    .sa6_code(sa6_q), .sa6_ins(sa6_ins), .ais(ais_to_net), .out_bit(to_net_out)
  );
  epc_crc_path u_to_user (
    .aclk(aclk), .aresetn(aresetn), .bit_stb(bit_stb), .in_bit(to_user_in),
    .regen(regen), .frame_in_smf(frame_in_smf), .sa6_slot(1'b0),
    .sa6_code(epc_pkg::SA6_NONE), .sa6_ins(1'b0), .ais(ais_to_user),
    .out_bit(to_user_out)
  );
endmodule

// ### epc_top_asserts.sv
// Port-level assertions for the E1 PRA CRC4 and clock select block
`timescale 1ns/1ps
module epc_top_chk #(
  parameter int RESEL_CYCLES = 200
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       u_los,
  input wire logic       u_lof,
  input wire logic       u_crc_err,
  input wire logic       n_los,
  input wire logic       n_lof,
  input wire logic       n_crc_err,
  input wire logic       bit_stb,
  input wire logic       to_net_in,
  input wire logic       to_user_in,
  input wire logic       to_net_out,
  input wire logic       to_user_out,
  input wire logic [1:0] tx_ref_sel,
  input wire logic [1:0] rx_ref_sel,
  input wire logic       crc_regen_net,
  input wire logic       crc_regen_user,
  input wire logic       ebit_to_user,
  input wire logic       ebit_to_net
);
  logic [1:0] sel_q;
  int         cnt_q;
  // Half a period of slack; picks come only on the tick, the first one a full period after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= 2'h0;
      cnt_q <= 0;
    end
    else
    begin
      sel_q <= tx_ref_sel;
      cnt_q <= (tx_ref_sel != sel_q) ? 0 : cnt_q + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet;
    !u_los && !u_lof && !n_los && !n_lof;
  endsequence
  sequence s_net_plain;
    bit_stb && !crc_regen_net ##0 s_quiet;
  endsequence
  sequence s_user_plain;
    bit_stb && !crc_regen_user ##0 s_quiet;
  endsequence
  a_net_pass: assert property (s_net_plain |=> to_net_out == $past(to_net_in))
    else $error("net stream altered");
  a_user_pass: assert property (s_user_plain |=> to_user_out == $past(to_user_in))
    else $error("user stream altered");
  a_ebit_user: assert property (u_crc_err && crc_regen_user |=> ebit_to_user)
    else $error("no E-bit toward user");
  a_ebit_net: assert property (n_crc_err && crc_regen_net |=> ebit_to_net)
    else $error("no E-bit toward exchange");
  a_ebit_cause: assert property (ebit_to_user |-> $past(u_crc_err))
    else $error("E-bit toward user without error");
  a_rx_no_ext: assert property (rx_ref_sel != epc_pkg::SRC_EXT)
    else $error("receive timed from external clock");
  a_sel_period: assert property (tx_ref_sel != sel_q |-> cnt_q >= RESEL_CYCLES / 2)
    else $error("clock selection moved too soon");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind epc_top epc_top_chk #(.RESEL_CYCLES(RESEL_CYCLES)) u_epc_top_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .u_los(u_los), .u_lof(u_lof), .u_crc_err(u_crc_err), .n_los(n_los), .n_lof(n_lof),
  .n_crc_err(n_crc_err), .bit_stb(bit_stb), .to_net_in(to_net_in), .to_user_in(to_user_in),
  .to_net_out(to_net_out), .to_user_out(to_user_out), .tx_ref_sel(tx_ref_sel),
  .rx_ref_sel(rx_ref_sel), .crc_regen_net(crc_regen_net), .crc_regen_user(crc_regen_user),
  .ebit_to_user(ebit_to_user), .ebit_to_net(ebit_to_net)
);

// ### tb_top.sv
// Self-checking bench for the E1 PRA CRC4 and clock select block
`timescale 1ns/1ps
module tb_top;
  localparam int RESEL = 200;
  logic aclk = 1'b0, aresetn = 1'b0, ext_ref_clk = 1'b0, e1_tx_clk = 1'b0, rem_rx_clk = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, c0;
  logic [3:0] s_axi_wstrb = 4'hF, los_v = 4'h0, code, icode;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, en_ext = 1'b0, en_tx = 1'b0, en_rem = 1'b0;
  logic u_crc_err = 1'b0, u_ebit_rx = 1'b0, n_crc_err = 1'b0, n, u, s;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_ref_sel, rx_ref_sel, frame_in_smf, rr, f;
  logic bit_stb, sa6_slot, to_net_in, to_user_in, to_net_out, to_user_out;
  logic crc_regen_net, crc_regen_user, crc_check, ebit_to_user, ebit_to_net;
  logic [7:0] cv [5] = '{8'h80, 8'h94, 8'hA4, 8'hA8, 8'hB0};
  int n_mismatch = 0, total_checks = 0, i, k, seed;
  always #2.5 aclk = ~aclk;
  // Pin clocks stop dead when absent; the odd offset keeps them off the aclk grid
  initial
  begin
    #1.3;
    forever
    begin
      #80;
      ext_ref_clk ^= en_ext;
      e1_tx_clk ^= en_tx;
      rem_rx_clk ^= en_rem;
    end
  end
  epc_top #(.RESEL_CYCLES(RESEL)) u_epc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_ref_clk(ext_ref_clk),
    .e1_tx_clk(e1_tx_clk), .rem_rx_clk(rem_rx_clk), .u_los(los_v[3]), .u_lof(los_v[2]),
    .u_crc_err(u_crc_err), .u_ebit_rx(u_ebit_rx), .n_los(los_v[1]), .n_lof(los_v[0]),
    .n_crc_err(n_crc_err), .bit_stb(bit_stb), .frame_in_smf(frame_in_smf), .sa6_slot(sa6_slot),
    .to_net_in(to_net_in), .to_user_in(to_user_in), .to_net_out(to_net_out),
    .to_user_out(to_user_out), .tx_ref_sel(tx_ref_sel), .rx_ref_sel(rx_ref_sel),
    .crc_regen_net(crc_regen_net), .crc_regen_user(crc_regen_user), .crc_check(crc_check),
    .ebit_to_user(ebit_to_user), .ebit_to_net(ebit_to_net));
  epc_e1_model u_epc_e1_model (.aclk(aclk), .aresetn(aresetn), .bit_stb(bit_stb),
    .frame_in_smf(frame_in_smf), .sa6_slot(sa6_slot), .to_net_in(to_net_in),
    .to_user_in(to_user_in));
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task tmo;
    n_mismatch++;
    end_of_test();
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] f_tx(input logic ext_on, input logic ext, input logic tx);
    return (ext_on && ext) ? epc_pkg::SRC_EXT : tx ? epc_pkg::SRC_TX : epc_pkg::SRC_INT;
  endfunction
  // Write and read hold every valid until the edge that takes it
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    int t;
    logic ta, tw, bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (bv)
        break;
    end
    s_axi_bready <= 1'b0;
    if (t == 50)
      tmo();
  endtask
  task axr(input logic [7:0] a);
    int t;
    logic ta, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      if (rv)
        break;
    end
    s_axi_rready <= 1'b0;
    if (t == 50)
      tmo();
  endtask
  // Returns just after the strobe edge, with the inputs it carried
  task stb;
    int t;
    // Leave the edge time step first so the model's strobe update has settled
    @(negedge aclk);
    for (t = 0; t < 20 && bit_stb !== 1'b1; t++)
      @(negedge aclk);
    if (t == 20)
      tmo();
    {n, u, s, f} = {to_net_in, to_user_in, sa6_slot, frame_in_smf};
    @(negedge aclk);
  endtask
  task sa6_get;
    int t;
    k = 0;
    for (t = 0; t < 300 && k < 4; t++)
    begin
      stb();
      if (s && (k > 0 || f == 2'h0))
      begin
        code = {code[2:0], to_net_out};
        icode = {icode[2:0], n};
        k++;
      end
    end
    if (k < 4)
      tmo();
  endtask
  task pulse(input logic c, input logic e, input logic nc);
    @(posedge aclk);
    {u_crc_err, u_ebit_rx, n_crc_err} <= {c, e, nc};
    @(posedge aclk);
    {u_crc_err, u_ebit_rx, n_crc_err} <= 3'h0;
  endtask
  initial
  begin
    seed = $urandom(32'hDD237E90);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(epc_pkg::ADDR_CTRL);
    chk(rd, epc_pkg::CTRL_RESET);
    axr(8'h10);
    chk({rr, rd}, {2'h2, 32'h0});
    axw(epc_pkg::ADDR_CNT_U, 32'h1, 4'hF);
    chk(rr, 2'h2);
    axw(epc_pkg::ADDR_CTRL, 32'hFFFF_FF80, 4'h1);
    axr(epc_pkg::ADDR_CTRL);
    chk(rd, 32'h80);
    for (i = 0; i < 5; i++)
    begin
      axw(epc_pkg::ADDR_CTRL, {24'h0, cv[i]}, 4'hF);
      axr(epc_pkg::ADDR_STATUS);
      chk(rd[11], i == 3);
      chk({crc_regen_net, crc_regen_user}, (i == 1 || i == 2) ? 2'h3 : 2'h0);
      chk(crc_check, i != 0 && i != 3);
    end
    for (i = 0; i < 4; i++)
    begin
      axw(epc_pkg::ADDR_CTRL, i[0] ? 32'hB0 : 32'h80, 4'hF);
      los_v <= 4'b1000 >> i;
      repeat (4) stb();
      repeat (8)
      begin
        stb();
        chk({to_net_out, to_user_out}, i < 2 ? {1'b1, u} : {n, 1'b1});
      end
    end
    @(posedge aclk);
    los_v <= 4'h0;
    for (i = 0; i < 6; i++)
    begin
      axw(epc_pkg::ADDR_CTRL, i < 2 ? 32'h80 : i < 4 ? 32'h94 : 32'hB0, 4'hF);
      axr(i[0] ? epc_pkg::ADDR_CNT_N : epc_pkg::ADDR_CNT_U);
      c0 = rd;
      k = $urandom_range(5, 1);
      repeat (k) pulse(!i[0], 1'b0, i[0]);
      axr(i[0] ? epc_pkg::ADDR_CNT_N : epc_pkg::ADDR_CNT_U);
      chk(rd, i < 2 ? c0 : c0 + k);
    end
    for (i = 1; i < 6; i++)
    begin
      axw(epc_pkg::ADDR_CTRL, i < 4 ? 32'hD4 : i == 4 ? 32'h94 : 32'hF0, 4'hF);
      sa6_get();
      pulse(i[1] || i > 3, i[0] || i > 3, 1'b0);
      sa6_get();
      sa6_get();
      chk(code, i < 4 ? i[3:0] : i == 4 ? epc_pkg::SA6_NONE : icode);
    end
    for (i = 0; i < 10; i++)
    begin
      axw(epc_pkg::ADDR_CTRL, i < 8 ? 32'h94 | i[2] : 32'h96, 4'hF);
      en_ext <= i < 8 && i[1];
      en_tx <= i > 7 || i[0];
      en_rem <= i > 7 && i[0];
      repeat (3 * RESEL + 200) @(posedge aclk);
      chk(tx_ref_sel, f_tx(i < 8 && i[2], en_ext, en_tx));
      if (i > 7)
        chk(rx_ref_sel, en_rem ? epc_pkg::SRC_REM : epc_pkg::SRC_INT);
    end
    end_of_test();
  end
endmodule
